// ---- eeprom_access_pkg.sv ----
// Constants shared by the data EEPROM access controller and its timing divider
package eeprom_access_pkg;

  // ----------------------------------------------------------------
  // I/O register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_HIGH_OFFSET = 6'h22;
  localparam logic [5:0] ADDR_LOW_OFFSET  = 6'h21;
  localparam logic [5:0] DATA_OFFSET      = 6'h20;
  localparam logic [5:0] CONTROL_OFFSET   = 6'h1f;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W         = 12;
  localparam int ADDR_HIGH_BITS = 4;
  localparam int MODE_HI_BIT    = 5;
  localparam int MODE_LO_BIT    = 4;
  localparam int RIE_BIT        = 3;
  localparam int MPE_BIT        = 2;
  localparam int PE_BIT         = 1;
  localparam int RE_BIT         = 0;

  // ----------------------------------------------------------------
  // Programming modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ATOMIC   = 2'h0;
  localparam logic [1:0] MODE_ERASE    = 2'h1;
  localparam logic [1:0] MODE_WRITE    = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [1:0] MODE_RESET    = 2'h0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int RC_FREQ_KHZ  = 8000;
  localparam int RC_DIV       = CLK_FREQ_KHZ / RC_FREQ_KHZ;
  localparam int ATOMIC_RC_CYCLES = 26368;
  localparam int SPLIT_TIME_US    = 1800;
  localparam int SPLIT_RC_CYCLES  = SPLIT_TIME_US * RC_FREQ_KHZ / 1000;
  localparam int PROG_CNT_W       = 15;
  localparam logic [2:0] MPE_CYCLES   = 3'h4;
  localparam logic [2:0] WRITE_STALL  = 3'h2;
  localparam logic [2:0] READ_STALL   = 3'h4;

  // ----------------------------------------------------------------
  // Programming engine states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PROG_IDLE,
    PROG_BUSY
  } prog_state_t;

endpackage

// ---- rc_tick_divider.sv ----
// Divider that stands in for the calibrated oscillator as a clock enable
`timescale 1ns/10ps

module rc_tick_divider
  import eeprom_access_pkg::*;
#(
  parameter int DIV = RC_DIV
)
(
  // Clock and power-on reset
  input  wire logic clock,
  input  wire logic por_n,
  // One-cycle enable at the oscillator rate
  output logic      tick
);

  localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  logic [CNT_W-1:0] count;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (count == LAST)
    begin
      count <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // rc_tick_divider

// ---- eeprom_cpu_access_control.sv ----
// CPU access controller for the on-chip data EEPROM behind I/O registers
//
// Notes on behaviour
// RULE1 - Address high bits 15:12 and control bits 7:6 always read zero.
// RULE2 - Address is 12 bits: high byte holds 11:8, low byte 7:0.
// RULE3 - Address is undefined after reset; software loads it before any access.
// RULE4 - Data register holds write byte, and receives byte fetched by a read.
// RULE5 - Mode 00 erase+write, 01 erase, 10 write, 11 reserved.
// RULE6 - Mode field writes are ignored while program enable is set.
// RULE7 - Reset clears the mode field unless programming is still running.
// RULE8 - Ready interrupt held while enabled, global enable set, program enable clear.
// RULE9 - Master enable clears itself four cycles after software sets it.
// RULE10 - Program enable starts a write only while master enable is set.
// RULE11 - Software waits idle, sets master enable, then program enable within four.
// RULE12 - Software never starts a write while flash programming runs.
// RULE13 - Program enable clears itself when the programming time ends.
// RULE14 - Starting a write stalls the CPU for two cycles.
// RULE15 - Read strobe fetches the byte at once, then stalls four cycles.
// RULE16 - During programming, reads are refused and the address is frozen.
// RULE17 - Software checks program enable is zero before a read.
// RULE18 - Programming time counts calibrated oscillator cycles, 26368 for a write. Code uses 26368 for mode 00 only; modes 01 and 10 take 14400.
// RULE19 - Software keeps interrupts off across the whole write sequence.
// RULE20 - Read strobe is a one-cycle pulse that clears itself.
// RULE21 - A write in progress at reset runs to completion.
`timescale 1ns/10ps

module eeprom_cpu_access_control
  import eeprom_access_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = ATOMIC_RC_CYCLES,
  parameter int unsigned SPLIT_CYCLES  = SPLIT_RC_CYCLES,
  parameter int unsigned TICK_DIV      = RC_DIV
)
(
  // Clock and resets
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              por_n,
  // I/O register port
  input  wire logic [5:0]        io_addr,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [7:0]        io_wdata,
  output logic      [7:0]        io_rdata,
  // CPU core signals
  input  wire logic              cpu_irq_enable,
  output logic                   ready_irq,
  output logic                   cpu_stall,
  // EEPROM array
  output logic      [ADDR_W-1:0] array_addr,
  output logic      [7:0]        array_wdata,
  input  wire logic [7:0]        array_rdata,
  output logic                   array_erase,
  output logic                   array_program
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  prog_state_t           state;
  logic [ADDR_W-1:0]     eeprom_address;
  logic [7:0]            eeprom_byte_data;
  logic [1:0]            program_mode_field;
  logic                  ready_irq_enable;
  logic                  master_program_enable;
  logic [2:0]            mpe_left;
  logic                  read_strobe;
  logic [2:0]            stall_left;
  logic [PROG_CNT_W-1:0] prog_left;
  logic                  rc_tick;
  logic                  busy;
  logic                  wr_high;
  logic                  wr_low;
  logic                  wr_data;
  logic                  wr_ctrl;
  logic                  start_write;
  logic                  start_read;
  logic                  prog_done;
  logic [1:0]            next_mode;
  logic [7:0]            next_rdata;
  logic [7:0]            control_view;

  // Decode of a write strobe to one offset
  function automatic logic hit(input logic [5:0] a, input logic [5:0] offset, input logic s);
    return s && (a == offset);
  endfunction

  // Programming time for a mode in oscillator cycles
  function automatic logic [PROG_CNT_W-1:0] prog_cycles(input logic [1:0] mode);
    if (mode == MODE_ATOMIC)
      return PROG_CNT_W'(ATOMIC_CYCLES);
    else
      return PROG_CNT_W'(SPLIT_CYCLES);
  endfunction

  assign busy    = (state == PROG_BUSY);
  assign wr_high = hit(io_addr, ADDR_HIGH_OFFSET, io_wr);
  assign wr_low  = hit(io_addr, ADDR_LOW_OFFSET, io_wr);
  assign wr_data = hit(io_addr, DATA_OFFSET, io_wr);
  assign wr_ctrl = hit(io_addr, CONTROL_OFFSET, io_wr);

  // Mode as it will stand after this write
  assign next_mode = (wr_ctrl && !busy) ? io_wdata[MODE_HI_BIT:MODE_LO_BIT] // RULE6
                                        : program_mode_field;

  // Reserved mode starts nothing
  assign start_write = wr_ctrl && io_wdata[PE_BIT] && master_program_enable // RULE10
                       && !busy && (next_mode != MODE_RESERVED); // RULE5

  assign start_read = wr_ctrl && io_wdata[RE_BIT] && !busy; // RULE16

  assign prog_done = busy && rc_tick && (prog_left <= 1);

  // ----------------------------------------------------------------
  // Oscillator enable
  // ----------------------------------------------------------------
  rc_tick_divider #(
    .DIV   (TICK_DIV)
  ) u_rc_tick (
    .clock (clock),
    .por_n (por_n),
    .tick  (rc_tick)
  );

  // ----------------------------------------------------------------
  // Address register, frozen while programming
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
      eeprom_address <= '0;
    else if (!busy) // RULE16
    begin
      if (wr_high)
        eeprom_address[ADDR_W-1:8] <= io_wdata[ADDR_HIGH_BITS-1:0]; // RULE2
      if (wr_low)
        eeprom_address[7:0] <= io_wdata; // RULE2
    end
  end

  assign array_addr = eeprom_address;

  // ----------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
      eeprom_byte_data <= BYTE_ZERO;
    else if (start_read)
      eeprom_byte_data <= array_rdata; // RULE4 RULE15
    else if (wr_data && !busy)
      eeprom_byte_data <= io_wdata; // RULE4
  end

  assign array_wdata = eeprom_byte_data;

  // ----------------------------------------------------------------
  // Programming mode, kept through reset while busy
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
      program_mode_field <= MODE_RESET;
    else if (!rst_n)
    begin
      if (!busy)
        program_mode_field <= MODE_RESET; // RULE7
    end
    else
      program_mode_field <= next_mode; // RULE6
  end

  // ----------------------------------------------------------------
  // Ready interrupt enable and request
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ready_irq_enable <= 1'b0;
    else if (wr_ctrl)
      ready_irq_enable <= io_wdata[RIE_BIT];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ready_irq <= 1'b0;
    else
      ready_irq <= ready_irq_enable && cpu_irq_enable && !busy; // RULE8
  end

  // ----------------------------------------------------------------
  // Master enable with its four-cycle timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_program_enable <= 1'b0;
      mpe_left              <= '0;
    end
    else if (wr_ctrl && io_wdata[MPE_BIT] && !master_program_enable)
    begin
      master_program_enable <= 1'b1;
      mpe_left              <= MPE_CYCLES - 3'h1; // RULE9
    end
    else if (wr_ctrl && !io_wdata[MPE_BIT])
    begin
      master_program_enable <= 1'b0;
      mpe_left              <= '0;
    end
    else if (mpe_left != 0)
      mpe_left <= mpe_left - 3'h1;
    else
      master_program_enable <= 1'b0; // RULE9
  end

  // ----------------------------------------------------------------
  // Programming engine, only power-on reset stops it
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      state     <= PROG_IDLE;
      prog_left <= '0;
    end
    else
    begin
      unique case (state)
        PROG_IDLE:
        begin
          if (start_write && rst_n)
          begin
            state     <= PROG_BUSY;
            prog_left <= prog_cycles(next_mode); // RULE18 RULE5
          end
        end
        PROG_BUSY:
        begin
          // Keeps running through a system reset
          if (prog_done)
            state <= PROG_IDLE; // RULE13 RULE21
          else if (rc_tick)
            prog_left <= prog_left - 1'b1; // RULE18
        end
      endcase
    end
  end

  // Array strobes follow the mode latched at start
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      array_erase   <= 1'b0;
      array_program <= 1'b0;
    end
    else if (start_write && rst_n)
    begin
      array_erase   <= (next_mode == MODE_ATOMIC) || (next_mode == MODE_ERASE); // RULE5
      array_program <= (next_mode == MODE_ATOMIC) || (next_mode == MODE_WRITE); // RULE5
    end
    else if (prog_done)
    begin
      array_erase   <= 1'b0;
      array_program <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read strobe pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      read_strobe <= 1'b0;
    else
      read_strobe <= start_read; // RULE20
  end

  // ----------------------------------------------------------------
  // CPU stall after a write start or a read
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_stall  <= 1'b0;
      stall_left <= '0;
    end
    else if (start_write)
    begin
      cpu_stall  <= 1'b1;
      stall_left <= WRITE_STALL - 3'h1; // RULE14
    end
    else if (start_read)
    begin
      cpu_stall  <= 1'b1;
      stall_left <= READ_STALL - 3'h1; // RULE15
    end
    else if (stall_left != 0)
      stall_left <= stall_left - 3'h1;
    else
      cpu_stall <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_comb
  begin
    control_view = BYTE_ZERO; // RULE1
    control_view[MODE_HI_BIT:MODE_LO_BIT] = program_mode_field;
    control_view[RIE_BIT] = ready_irq_enable;
    control_view[MPE_BIT] = master_program_enable;
    control_view[PE_BIT]  = busy;
    control_view[RE_BIT]  = read_strobe;
  end

  always_comb
  begin
    next_rdata = BYTE_ZERO;
    if (io_rd)
    begin
      unique case (io_addr)
        ADDR_HIGH_OFFSET:
          next_rdata = {4'h0, eeprom_address[ADDR_W-1:8]}; // RULE1
        ADDR_LOW_OFFSET:
          next_rdata = eeprom_address[7:0];
        DATA_OFFSET:
          next_rdata = eeprom_byte_data;
        CONTROL_OFFSET:
          next_rdata = control_view;
        default:
          next_rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      io_rdata <= BYTE_ZERO;
    else
      io_rdata <= next_rdata;
  end

endmodule // eeprom_cpu_access_control

// ---- eeprom_access_props.sv ----
// Port-level checks for the EEPROM access controller
`timescale 1ns/10ps

module eeprom_access_props
  import eeprom_access_pkg::*;
(
  // Watched ports
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              por_n,
  input wire logic [5:0]        io_addr,
  input wire logic              io_wr,
  input wire logic              io_rd,
  input wire logic [7:0]        io_wdata,
  input wire logic [7:0]        io_rdata,
  input wire logic              cpu_irq_enable,
  input wire logic              ready_irq,
  input wire logic              cpu_stall,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic [7:0]        array_wdata,
  input wire logic [7:0]        array_rdata,
  input wire logic              array_erase,
  input wire logic              array_program
);
  logic busy;
  logic ctl_wr;
  assign busy   = array_erase | array_program;
  assign ctl_wr = io_wr && io_addr == CONTROL_OFFSET;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !por_n);

  chk_write_stall: assert property (
    $rose(busy) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("write stall length wrong");
  chk_read_stall: assert property (
    ctl_wr && io_wdata[1:0] == 2'h1 && !busy |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  chk_read_refused: assert property (
    ctl_wr && io_wdata[0] && busy |=> ##2 !cpu_stall)
    else $error("read accepted while busy");
  chk_addr_frozen: assert property (
    busy |=> $stable(array_addr) && $stable(array_wdata))
    else $error("address or data moved while busy");
  chk_irq_cause: assert property (
    ready_irq |-> $past(cpu_irq_enable) && !$past(busy))
    else $error("ready request without cause");
  chk_addr_high_zero: assert property (
    $past(io_rd) && $past(io_addr) == ADDR_HIGH_OFFSET |-> io_rdata[7:4] == 4'h0)
    else $error("address high upper bits not zero");
  chk_ctrl_top_zero: assert property (
    $past(io_rd) && $past(io_addr) == CONTROL_OFFSET |-> io_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  chk_read_fetch: assert property (
    ctl_wr && io_wdata[1:0] == 2'h1 && !busy |=> array_wdata == $past(array_rdata))
    else $error("read did not load data register");
  chk_addr_load: assert property (
    io_wr && io_addr == ADDR_LOW_OFFSET && !busy |=> array_addr[7:0] == $past(io_wdata))
    else $error("address low not loaded");
endmodule // eeprom_access_props

bind eeprom_cpu_access_control eeprom_access_props eeprom_access_props_inst (
  .clock(clock), .rst_n(rst_n), .por_n(por_n), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .cpu_irq_enable(cpu_irq_enable), .ready_irq(ready_irq), .cpu_stall(cpu_stall),
  .array_addr(array_addr), .array_wdata(array_wdata), .array_rdata(array_rdata),
  .array_erase(array_erase), .array_program(array_program));

// ---- eeprom_array_model.sv ----
// Behavioural EEPROM array behind the access controller
`timescale 1ns/10ps

module eeprom_array_model
  import eeprom_access_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Array side
  input  wire logic [ADDR_W-1:0] array_addr,
  input  wire logic [7:0]        array_wdata,
  input  wire logic              array_erase,
  input  wire logic              array_program,
  output logic      [7:0]        array_rdata
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic       erase_seen;
  logic       prog_seen;

  initial
  begin
    for (int i = 0; i < (1 << ADDR_W); i++)
      mem[i] = i[7:0] ^ 8'h5a;
    erase_seen = 1'b0;
    prog_seen  = 1'b0;
  end

  assign array_rdata = mem[array_addr];

  // Byte changes only once the operation has ended
  always @(posedge clock)
  begin
    if (array_erase || array_program)
    begin
      erase_seen <= erase_seen | array_erase;
      prog_seen  <= prog_seen | array_program;
    end
    else if (erase_seen || prog_seen)
    begin
      mem[array_addr] <= (erase_seen ? 8'hff : mem[array_addr])
                         & (prog_seen ? array_wdata : 8'hff);
      erase_seen      <= 1'b0;
      prog_seen       <= 1'b0;
    end
  end
endmodule // eeprom_array_model

// ---- tb.sv ----
// Self-checking bench for the EEPROM access controller
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module tb
  import eeprom_access_pkg::*;
;
  localparam int A = 20;
  localparam int S = 10;
  localparam int D = 2;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              por_n = 1'b0;
  logic [5:0]        io_addr = 6'h00;
  logic              io_wr = 1'b0;
  logic              io_rd = 1'b0;
  logic [7:0]        io_wdata = 8'h00;
  logic [7:0]        io_rdata;
  logic              cpu_irq_enable = 1'b0;
  logic              ready_irq;
  logic              cpu_stall;
  logic [ADDR_W-1:0] array_addr;
  logic [7:0]        array_wdata;
  logic [7:0]        array_rdata;
  logic              array_erase;
  logic              array_program;
  int                err_count = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                busy_len = 0;

  eeprom_cpu_access_control #(.ATOMIC_CYCLES(A), .SPLIT_CYCLES(S), .TICK_DIV(D))
  eeprom_cpu_access_control_inst (.clock(clock), .rst_n(rst_n), .por_n(por_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_irq_enable(cpu_irq_enable), .ready_irq(ready_irq),
    .cpu_stall(cpu_stall), .array_addr(array_addr), .array_wdata(array_wdata),
    .array_rdata(array_rdata), .array_erase(array_erase), .array_program(array_program));

  eeprom_array_model eeprom_array_model_inst (.clock(clock), .array_addr(array_addr),
    .array_wdata(array_wdata), .array_erase(array_erase), .array_program(array_program),
    .array_rdata(array_rdata));

  always #5 clock = ~clock;

  // Operation length and hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (array_erase || array_program)
      busy_len <= busy_len + 1;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge clock);
    io_wr    = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clock);
    io_rd   = 1'b0;
    d       = io_rdata;
  endtask

  task automatic run_op;
    int n;
    n = 0;
    while ((array_erase || array_program) && n < 500)
    begin
      @(negedge clock);
      n++;
    end
    // Array commits the byte on the edge after the strobes drop
    @(negedge clock);
    `CHK("done", 1'b1, n < 500)
  endtask

  task automatic t_regs;
    logic [7:0] d;
    rd(CONTROL_OFFSET, d);
    `CHK("ctrl reset", 8'h00, d)
    wr(ADDR_HIGH_OFFSET, 8'hfa);
    wr(ADDR_LOW_OFFSET, 8'h5c);
    wr(DATA_OFFSET, 8'h3c);
    rd(ADDR_HIGH_OFFSET, d);
    `CHK("addr high", 8'h0a, d)
    `CHK("addr", 12'ha5c, array_addr)
    rd(6'h10, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  task automatic t_write;
    logic [7:0] d;
    wr(CONTROL_OFFSET, 8'h04);
    repeat (4) @(negedge clock);
    wr(CONTROL_OFFSET, 8'h02);
    `CHK("late strobe", 1'b0, array_program)
    wr(CONTROL_OFFSET, 8'h04);
    busy_len = 0;
    wr(CONTROL_OFFSET, 8'h06);
    `CHK("atomic", 2'h3, {array_erase, array_program})
    rd(CONTROL_OFFSET, d);
    `CHK("busy bit", 1'b1, d[1])
    wr(ADDR_LOW_OFFSET, 8'h00);
    wr(CONTROL_OFFSET, 8'h21);
    `CHK("frozen addr", 12'ha5c, array_addr)
    `CHK("frozen data", 8'h3c, array_wdata)
    run_op();
    `CHK("len", 1'b1, busy_len >= (A - 1) * D && busy_len <= (A + 1) * D)
    `CHK("byte", 8'h3c, eeprom_array_model_inst.mem[12'ha5c])
    rd(CONTROL_OFFSET, d);
    `CHK("ctrl idle", 8'h00, d)
  endtask

  task automatic t_modes;
    logic [7:0] d;
    logic [7:0] ex;
    for (int m = 1; m < 4; m++)
    begin
      wr(ADDR_LOW_OFFSET, 8'(m));
      wr(DATA_OFFSET, 8'h0f);
      wr(CONTROL_OFFSET, 8'(m << 4));
      wr(CONTROL_OFFSET, 8'(m << 4) | 8'h04);
      busy_len = 0;
      wr(CONTROL_OFFSET, 8'(m << 4) | 8'h06);
      `CHK("erase", m == 1, array_erase)
      `CHK("program", m == 2, array_program)
      run_op();
      `CHK("len", 1'b1, m == 3 ? busy_len == 0 : busy_len >= (S - 1) * D && busy_len <= (S + 1) * D)
      ex = m == 1 ? 8'hff : (8'(m) ^ 8'h5a) & (m == 2 ? 8'h0f : 8'hff);
      rd(CONTROL_OFFSET, d);
      `CHK("pe clear", 1'b0, d[1])
      wr(CONTROL_OFFSET, 8'(m << 4) | 8'h01);
      rd(DATA_OFFSET, d);
      `CHK("fetch", ex, d)
      rd(CONTROL_OFFSET, d);
      `CHK("ctrl", 8'(m << 4), d)
    end
  endtask

  task automatic t_irq;
    cpu_irq_enable = 1'b1;
    wr(CONTROL_OFFSET, 8'h08);
    @(negedge clock);
    `CHK("irq on", 1'b1, ready_irq)
    cpu_irq_enable = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("irq gated", 1'b0, ready_irq)
    cpu_irq_enable = 1'b0;
    wr(CONTROL_OFFSET, 8'h0c);
    wr(CONTROL_OFFSET, 8'h0e);
    cpu_irq_enable = 1'b1;
    @(negedge clock);
    `CHK("irq busy", 1'b0, ready_irq)
    run_op();
    repeat (2) @(negedge clock);
    `CHK("irq ready", 1'b1, ready_irq)
    cpu_irq_enable = 1'b0;
  endtask

  task automatic t_reset;
    logic [7:0] d;
    wr(CONTROL_OFFSET, 8'h10);
    wr(CONTROL_OFFSET, 8'h14);
    wr(CONTROL_OFFSET, 8'h16);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("erase on", 1'b1, array_erase)
    rst_n = 1'b1;
    run_op();
    `CHK("erased", 8'hff, eeprom_array_model_inst.mem[12'ha03])
    rd(CONTROL_OFFSET, d);
    `CHK("mode kept", 8'h10, d)
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rd(CONTROL_OFFSET, d);
    `CHK("mode cleared", 8'h00, d)
  endtask

  initial
  begin
    repeat (16) @(negedge clock);
    por_n = 1'b1;
    rst_n = 1'b1;
    t_regs();
    t_write();
    t_modes();
    t_irq();
    t_reset();
    close_out();
  end
endmodule // tb
